// [rtl/i2c_flags_pkg.sv]
// shared constants for the i2c protocol status and event flag block
package i2c_flags_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [11:0] status_offset = 12'h000;
   localparam logic [11:0] control_offset = 12'h004;
   localparam logic [31:0] status_reset = 32'h0000_0000;
   localparam logic [31:0] control_reset = 32'h0000_0000;

   // ****************************************************************
   // status field positions
   // ****************************************************************
   localparam int timeout_bit = 5;
   localparam int busy_bit = 6;
   localparam int start_bit = 8;
   localparam int stop_bit = 9;
   localparam int nack_bit = 10;
   localparam int arb_bit = 11;
   localparam int error_bit = 12;
   localparam int ack_bit = 13;
   localparam int event_count = 6;

   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int enable_low_bit = 8;
   localparam int release_bit = 31;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int core_clk_mhz = 25;
   localparam int sync_stages = 2;

endpackage : i2c_flags_pkg

// [rtl/i2c_bus_monitor.sv]
// start and stop condition detector on the link sampling clock
`timescale 1ns/10ps
module i2c_bus_monitor (
   // link clock and reset
   input wire logic link_clk,
   input wire logic nrst,
   // bus line levels from the pins
   input wire logic scl_in,
   input wire logic sda_in,
   // events and level toward the core domain
   output logic busy_level,
   output logic start_toggle,
   output logic rstart_toggle,
   output logic stop_toggle
);

   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic sda_prev_reg;
   logic scl_prev_reg;
   logic start_cond;
   logic stop_cond;

   // two flip-flop synchronisers for the bus lines
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
      end
   end

   // previous settled levels for edge detection
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         scl_prev_reg <= 1'h1;
         sda_prev_reg <= 1'h1;
      end else begin
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end

   // sda falling while scl high is start, rising is stop
   assign start_cond = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
   assign stop_cond = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];

   // bus busy level and event toggles
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         busy_level <= 1'h0;
         start_toggle <= 1'h0;
         rstart_toggle <= 1'h0;
         stop_toggle <= 1'h0;
      end else begin
         if (start_cond) begin
            busy_level <= 1'h1;
            start_toggle <= ~start_toggle;
            if (busy_level) begin
               rstart_toggle <= ~rstart_toggle;
            end
         end else if (stop_cond) begin
            busy_level <= 1'h0;
            stop_toggle <= ~stop_toggle;
         end
      end
   end

endmodule : i2c_bus_monitor

// [rtl/i2c_protocol_status_flags.sv]
// protocol status flags, interrupt enables and apb register port
`timescale 1ns/10ps

module i2c_protocol_status_flags (
   // core clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link sampling clock and bus lines
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   // events from the shifter, core clock domain
   input wire logic master_mode,
   input wire logic frame_shifting,
   input wire logic ack_received,
   input wire logic nack_received,
   input wire logic arb_lost,
   input wire logic timeout_hit,
   // outputs toward the controller
   output logic protocol_irq,
   output logic bus_release_request,
   output logic bus_activity_flag
);

   // ****************************************************************
   // link domain monitor
   // ****************************************************************
   // busy level and event toggles, link clock domain
   logic link_busy;
   logic link_start_tgl;
   logic link_rstart_tgl;
   logic link_stop_tgl;

   i2c_bus_monitor u_monitor (
      .link_clk(link_clk),
      .nrst(nrst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .busy_level(link_busy),
      .start_toggle(link_start_tgl),
      .rstart_toggle(link_rstart_tgl),
      .stop_toggle(link_stop_tgl)
   );

   // ****************************************************************
   // crossing into the core domain
   // ****************************************************************
   // toggles from the link domain, one bit per bus event
   logic [2:0] link_tgl;
   // busy level after two core flops
   logic [1:0] busy_sync_reg;
   // one pulse per toggle change, in core clock cycles
   logic [2:0] tgl_evt;
   logic start_evt;
   logic rstart_evt;
   logic stop_evt;

   // bit 0 start, bit 1 repeated start, bit 2 stop
   assign link_tgl = {link_stop_tgl, link_rstart_tgl, link_start_tgl};

   // two flops for the busy level; a level needs no edge detection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_sync_reg <= 2'h0;
      end else begin
         busy_sync_reg <= {busy_sync_reg[0], link_busy};
      end
   end

   // a toggle changes once per event, so no event is lost to the slower clock;
   // two events of one kind closer than one core cycle would cancel out and neither would be seen
   genvar ti;
   generate
      for (ti = 0; ti < 3; ti = ti + 1) begin : g_cross
         logic [2:0] tgl_sync_reg;
         // two synchroniser flops, a third flop holds the previous level
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               tgl_sync_reg <= 3'h0;
            end else begin
               tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl[ti]};
            end
         end
         // only the settled second stage and its history are compared
         assign tgl_evt[ti] = tgl_sync_reg[2] ^ tgl_sync_reg[1];
      end
   endgenerate

   // name the event pulses
   assign start_evt = tgl_evt[0];
   assign rstart_evt = tgl_evt[1];
   assign stop_evt = tgl_evt[2];

   // ****************************************************************
   // event sources
   // ****************************************************************
   // one bit per event flag, bit 0 is the start flag
   logic [i2c_flags_pkg::event_count-1:0] event_set;
   logic [i2c_flags_pkg::event_count-1:0] event_clr;
   logic [i2c_flags_pkg::event_count-1:0] event_reg;
   // interrupt enables, same order as the flags
   logic [i2c_flags_pkg::event_count-1:0] enable_reg;
   // time-out flag has no enable and no interrupt
   logic timeout_reg;
   // completed apb writes
   logic status_write;
   logic control_write;
   logic apb_commit;

   // set conditions, one bit per event flag
   always_comb begin
      event_set = '0;
      // master start or repeated start, slave repeated start only
      event_set[i2c_flags_pkg::start_bit - i2c_flags_pkg::enable_low_bit] =
         (start_evt & master_mode) | (rstart_evt & ~master_mode);
      event_set[i2c_flags_pkg::stop_bit - i2c_flags_pkg::enable_low_bit] = stop_evt;
      event_set[i2c_flags_pkg::nack_bit - i2c_flags_pkg::enable_low_bit] =
         nack_received & master_mode;
      event_set[i2c_flags_pkg::arb_bit - i2c_flags_pkg::enable_low_bit] = arb_lost;
      // a start or stop while a byte or ack bit is shifting is illegal
      event_set[i2c_flags_pkg::error_bit - i2c_flags_pkg::enable_low_bit] =
         (start_evt | stop_evt) & frame_shifting;
      event_set[i2c_flags_pkg::ack_bit - i2c_flags_pkg::enable_low_bit] =
         ack_received & master_mode;
   end

   // ****************************************************************
   // apb handshake
   // ****************************************************************
   // address decode of the two registers
   logic addr_status;
   logic addr_control;
   logic addr_mapped;

   // a transfer commits only at the edge where pready is seen high
   assign addr_status = (paddr == i2c_flags_pkg::status_offset);
   assign addr_control = (paddr == i2c_flags_pkg::control_offset);
   assign addr_mapped = addr_status | addr_control;
   assign apb_commit = psel & penable & pready;
   assign status_write = apb_commit & pwrite & addr_status;
   assign control_write = apb_commit & pwrite & addr_control;

   // ****************************************************************
   // apb response
   // ****************************************************************
   // one wait state: pready rises in the second access cycle;
   // the extra cycle lets read data be captured from settled flags
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'h0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // error answer for unmapped addresses
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pslverr <= 1'h0;
      end else begin
         pslverr <= psel & penable & ~pready & ~addr_mapped;
      end
   end

   // ****************************************************************
   // event flags
   // ****************************************************************
   // clear only where a one is written
   assign event_clr = status_write ?
      pwdata[i2c_flags_pkg::ack_bit:i2c_flags_pkg::start_bit] : '0;

   // each flag is sticky; a set in the clearing cycle wins,
   // so an event that meets a clearing write is never lost
   genvar gi;
   generate
      for (gi = 0; gi < i2c_flags_pkg::event_count; gi = gi + 1) begin : g_flag
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               event_reg[gi] <= i2c_flags_pkg::status_reset[gi + i2c_flags_pkg::start_bit];
            end else begin
               event_reg[gi] <= event_set[gi] | (event_reg[gi] & ~event_clr[gi]);
            end
         end
      end
   endgenerate

   // ****************************************************************
   // time-out flag
   // ****************************************************************
   // timeout flag, sticky until one is written; a new time-out
   // in the clearing cycle wins, like the event flags
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timeout_reg <= i2c_flags_pkg::status_reset[i2c_flags_pkg::timeout_bit];
      end else begin
         timeout_reg <= timeout_hit |
            (timeout_reg & ~(status_write & pwdata[i2c_flags_pkg::timeout_bit]));
      end
   end

   // ****************************************************************
   // protocol control register
   // ****************************************************************
   // per-flag interrupt enables
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         enable_reg <= i2c_flags_pkg::control_reset[i2c_flags_pkg::ack_bit:i2c_flags_pkg::start_bit];
      end else if (control_write) begin
         enable_reg <= pwdata[i2c_flags_pkg::ack_bit:i2c_flags_pkg::start_bit];
      end
   end

   // ****************************************************************
   // bus release request
   // ****************************************************************
   // release request pulses for one cycle when one is written;
   // software uses it after a bus error as slave to leave the frame
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bus_release_request <= 1'h0;
      end else begin
         bus_release_request <= control_write & pwdata[i2c_flags_pkg::release_bit];
      end
   end

   // ****************************************************************
   // status outputs
   // ****************************************************************
   // activity follows the synchronised busy level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bus_activity_flag <= 1'h0;
      end else begin
         bus_activity_flag <= busy_sync_reg[1];
      end
   end

   // ****************************************************************
   // protocol interrupt
   // ****************************************************************
   // protocol interrupt from enabled flags; a level that
   // stays high until every enabled flag is cleared
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         protocol_irq <= 1'h0;
      end else begin
         protocol_irq <= |(event_reg & enable_reg);
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   // register images as software reads them
   logic [31:0] status_word;
   logic [31:0] control_word;

   // reserved positions stay zero
   always_comb begin
      status_word = '0;
      status_word[i2c_flags_pkg::ack_bit:i2c_flags_pkg::start_bit] = event_reg;
      status_word[i2c_flags_pkg::busy_bit] = bus_activity_flag;
      status_word[i2c_flags_pkg::timeout_bit] = timeout_reg;
      control_word = '0;
      control_word[i2c_flags_pkg::ack_bit:i2c_flags_pkg::start_bit] = enable_reg;
   end

   // read data captured in the first access cycle, held to the end;
   // a flag set after the capture shows at the next read
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & penable & ~pready & ~pwrite) begin
         if (addr_status) begin
            prdata <= status_word;
         end else if (addr_control) begin
            prdata <= control_word;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule : i2c_protocol_status_flags

// [tb/flags_monitor.sv]
// port assertions for the protocol flag block
`timescale 1ns/10ps
module flags_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // bus lines and events
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic master_mode,
   input wire logic ack_received,
   input wire logic nack_received,
   input wire logic arb_lost,
   // flag outputs
   input wire logic protocol_irq,
   input wire logic bus_activity_flag
);
   logic wacc;
   logic [5:0] en_reg;
   // shadow of the interrupt enables, taken at each completed write to the control register
   assign wacc = psel && penable && pready && pwrite;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_reg <= 6'h00;
      end else if (wacc && paddr == i2c_flags_pkg::control_offset) begin
         en_reg <= pwdata[13:8];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   AST_START_BUSY: assert property ($fell(sda_in) && scl_in |-> ##[1:16] bus_activity_flag)
      else $error("busy not raised after start");
   AST_STOP_IDLE: assert property ($rose(sda_in) && scl_in |-> ##[1:16] !bus_activity_flag)
      else $error("busy not cleared after stop");
   AST_STOP_IRQ: assert property ($rose(sda_in) && scl_in && en_reg[1] |-> ##[1:16] protocol_irq)
      else $error("no irq after stop");
   AST_NACK_IRQ: assert property (nack_received && master_mode && en_reg[2] |-> ##2 protocol_irq)
      else $error("no irq after nack");
   AST_ARB_IRQ: assert property (arb_lost && en_reg[3] |-> ##2 protocol_irq)
      else $error("no irq after arbitration loss");
   AST_ACK_IRQ: assert property (ack_received && master_mode && en_reg[5] |-> ##2 protocol_irq)
      else $error("no irq after ack");
   AST_IRQ_HOLD: assert property (protocol_irq && !wacc && !$past(wacc) |=> protocol_irq)
      else $error("irq dropped without a write");
   AST_PREADY_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("access wait wrong");
   AST_UNMAPPED: assert property (pready && paddr != 12'h000 && paddr != 12'h004
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
endmodule : flags_monitor

// [tb/i2c_far_end.sv]
// far end of the two-wire bus: makes start and stop conditions
`timescale 1ns/10ps
module i2c_far_end (
   // link clock
   input wire logic link_clk,
   // bus lines, pulled high when idle
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // wait some link clock edges
   task automatic hold(input int n);
      repeat (n) @(posedge link_clk);
   endtask : hold
   // start or repeated start, then clock held low
   task automatic start_cond();
      hold(1);
      sda <= 1'b1;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda <= 1'b0;
      hold(30);
      scl <= 1'b0;
      hold(4);
   endtask : start_cond
   // stop, then bus left idle
   task automatic stop_cond();
      hold(1);
      sda <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda <= 1'b1;
      hold(30);
   endtask : stop_cond
endmodule : i2c_far_end

// [tb/tb.sv]
// testbench for the protocol status and event flag block
`timescale 1ns/10ps
module tb;
   logic core_clk, link_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic scl_in, sda_in, master_mode, frame_shifting, protocol_irq, bus_release_request, bus_activity_flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] ev;
   int err_total, n_compared, rel_count;
   i2c_protocol_status_flags uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .scl_in(scl_in), .sda_in(sda_in), .master_mode(master_mode), .frame_shifting(frame_shifting),
      .ack_received(ev[0]), .nack_received(ev[1]), .arb_lost(ev[2]), .timeout_hit(ev[3]),
      .protocol_irq(protocol_irq), .bus_release_request(bus_release_request), .bus_activity_flag(bus_activity_flag));
   i2c_far_end far (.link_clk(link_clk), .scl(scl_in), .sda(sda_in));
   // clocks, link clock offset in phase
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   always @(posedge core_clk) if (bus_release_request === 1'b1) rel_count++;
   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk("pready", 32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rchk
   task automatic pulse(input int k);
      @(posedge core_clk);
      ev[k] <= 1'b1;
      @(posedge core_clk);
      ev[k] <= 1'b0;
   endtask : pulse
   // reset values, read-back, release pulse, unmapped address
   task automatic t_regs();
      rchk("status reset", 12'h000, 32'h0);
      rchk("control reset", 12'h004, 32'h0);
      apb(1'b1, 12'h004, 32'hffff_ffff);
      rchk("control", 12'h004, 32'h0000_3f00);
      chk("release pulses", 32'(rel_count), 32'h1);
      apb(1'b1, 12'h000, 32'hffff_ffff);
      rchk("status reserved", 12'h000, 32'h0);
      rchk("unmapped data", 12'h008, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      $display("test regs done");
   endtask : t_regs
   // master start and stop on the bus
   task automatic t_bus();
      master_mode <= 1'b1;
      far.start_cond();
      rchk("master start", 12'h000, 32'h0000_0140);
      chk("start irq", {31'h0, protocol_irq}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      rchk("zero write", 12'h000, 32'h0000_0140);
      apb(1'b1, 12'h000, 32'h0000_0100);
      rchk("start cleared", 12'h000, 32'h0000_0040);
      far.stop_cond();
      rchk("stop", 12'h000, 32'h0000_0200);
      apb(1'b1, 12'h000, 32'h0000_0200);
      $display("test bus done");
   endtask : t_bus
   // event pulses in slave and master mode
   task automatic t_events();
      logic [31:0] tbl [4] = '{32'h2000, 32'h0400, 32'h0800, 32'h0020};
      logic [31:0] exp;
      for (int m = 0; m < 2; m++) begin
         master_mode <= m[0];
         for (int k = 0; k < 4; k++) begin
            pulse(k);
            exp = (k < 2 && m == 0) ? 32'h0 : tbl[k];
            rchk("event flag", 12'h000, exp);
            chk("event irq", {31'h0, protocol_irq}, {31'h0, |exp[13:8]});
            apb(1'b1, 12'h000, exp);
            rchk("event cleared", 12'h000, 32'h0);
         end
      end
      $display("test events done");
   endtask : t_events
   // slave start, repeated start inside a frame, stop
   task automatic t_error();
      master_mode <= 1'b0;
      far.start_cond();
      rchk("slave start", 12'h000, 32'h0000_0040);
      frame_shifting <= 1'b1;
      far.start_cond();
      rchk("start in frame", 12'h000, 32'h0000_1140);
      frame_shifting <= 1'b0;
      far.stop_cond();
      rchk("stop after error", 12'h000, 32'h0000_1300);
      apb(1'b1, 12'h000, 32'h0000_1300);
      // slave start outside a frame, then a stop while a byte shifts
      far.start_cond();
      @(posedge core_clk);
      frame_shifting <= 1'b1;
      far.stop_cond();
      @(posedge core_clk);
      frame_shifting <= 1'b0;
      rchk("stop in frame", 12'h000, 32'h0000_1200);
      apb(1'b1, 12'h000, 32'h0000_1200);
      $display("test error done");
   endtask : t_error
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   initial begin
      {nrst, psel, penable, pwrite, master_mode, frame_shifting} = 6'h00;
      {paddr, pwdata, ev} = 48'h0;
      {err_total, n_compared, rel_count} = 96'h0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_bus();
      t_events();
      t_error();
      results();
   end
   // watchdog against a hang
   initial begin
      #400000;
      err_total++;
      results();
   end
endmodule : tb
bind i2c_protocol_status_flags flags_monitor mon (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .sda_in(sda_in), .master_mode(master_mode), .ack_received(ack_received),
   .nack_received(nack_received), .arb_lost(arb_lost), .protocol_irq(protocol_irq),
   .bus_activity_flag(bus_activity_flag));
